// file: apc_analog_pin_config.sv
//----------------------------------------------------------------------
// Purpose: analog pin assignment and direction registers for port 2,
//          with the per-pin function mux and converter channel pick
// Assumes: single mclk, synchronous reset, cpu holds a request while
//          cpu_wait is high
// Notes:   pin outputs are registered, one cycle behind configuration
//----------------------------------------------------------------------
// What this block does
// - pin-select code n makes pins below n digital; code 8 all digital.
// - analog assignment register resets to 08h, all digital, read/write.
// - every write to the assignment register costs one wait cycle.
// - segment function select forces segment output regardless of assignment.
// - output latch is ignored for analog input pins.
// - a pin in output mode never works as analog input.
// - direction 0 means output mode, buffer enabled.
// - direction 1 means input mode, buffer disabled.
// - direction register resets to ffh, byte or single-bit writable.
// - analog input pin is converted only when the selector picks it.
// - unpicked analog input pin stays unconverted, digital path inactive.
// - three-bit channel code picks analog pin 0 to 7.
`timescale 1ns/100ps
`default_nettype none

module apc_analog_pin_config
	import apc_pkg::*;
#(
	parameter int PINS = APC_PINS
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// cpu register port
	input wire apc_cpu_req_t cpu_req,
	output logic cpu_wait,
	output logic [7:0] cpu_rdata,
	// from neighbouring registers
	input wire logic [APC_CHAN_W-1:0] channel_selector,
	input wire logic [PINS-1:0] port2_function_select,
	input wire logic [PINS-1:0] port2_latch,
	input wire logic [PINS-1:0] segment_data,
	// pads
	input wire logic [PINS-1:0] pad_in,
	output logic [PINS-1:0] pad_out,
	output logic [PINS-1:0] pad_oe,
	// toward port read path and converter
	output logic [PINS-1:0] port2_digital_in,
	output logic [PINS-1:0] convert_pin
);

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [7:0] analog_pin_assignment;
	logic [7:0] port2_direction;
	logic wait_done;
	logic [7:0] next_analog_pin_assignment;
	logic [7:0] next_port2_direction;
	logic next_wait_done;
	logic [7:0] next_cpu_rdata;
	logic hit_apa;
	logic hit_dir;
	logic [PINS-1:0] analog_mask;
	logic [PINS-1:0] chan_hit;
	logic [PINS-1:0] next_pad_out;
	logic [PINS-1:0] next_pad_oe;
	logic [PINS-1:0] next_dig_in;
	logic [PINS-1:0] next_convert;

	assign hit_apa = cpu_req.addr == APC_ADDR_APA;
	assign hit_dir = cpu_req.addr == APC_ADDR_DIR;

	// first cycle of an assignment write is stalled
	assign cpu_wait = cpu_req.wr && hit_apa && !wait_done;

	// register update; the wait keeps the write from taking effect until the cpu has been held once
	always_comb
	begin
		next_analog_pin_assignment = analog_pin_assignment;
		next_port2_direction = port2_direction;
		next_wait_done = 1'b0;
		next_cpu_rdata = cpu_rdata;
		if (cpu_req.wr && hit_apa)
		begin
			next_wait_done = !wait_done;
			if (wait_done)
				next_analog_pin_assignment = ((analog_pin_assignment & ~cpu_req.wmask)
					| (cpu_req.wdata & cpu_req.wmask)) & APC_SEL_MASK;
		end
		// bit or byte writes via mask
		if (cpu_req.wr && hit_dir)
			next_port2_direction = (port2_direction & ~cpu_req.wmask) | (cpu_req.wdata & cpu_req.wmask);
		if (cpu_req.rd)
		begin
			if (hit_apa)
				next_cpu_rdata = analog_pin_assignment;
			else if (hit_dir)
				next_cpu_rdata = port2_direction;
			else
				next_cpu_rdata = 8'h00;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			analog_pin_assignment <= APC_APA_RESET;
			port2_direction <= APC_DIR_RESET;
			wait_done <= 1'b0;
			cpu_rdata <= 8'h00;
		end
		else
		begin
			analog_pin_assignment <= next_analog_pin_assignment;
			port2_direction <= next_port2_direction;
			wait_done <= next_wait_done;
			cpu_rdata <= next_cpu_rdata;
		end
	end

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------

	// prohibited codes above 8 are treated as all digital, the safe side for the pads
	// thermometer pin decode
	always_comb
	begin
		analog_mask = '0;
		for (int i = 0; i < PINS; i++)
			if (analog_pin_assignment[APC_SEL_W-1:0] <= APC_SEL_ALL_DIGITAL)
				analog_mask[i] = i >= int'(analog_pin_assignment[APC_SEL_W-1:0]);
	end

	always_comb
	begin
		chan_hit = '0;
		chan_hit[channel_selector] = 1'b1;
	end

	// ------------------------------------------------------------------
	// pin cells
	// ------------------------------------------------------------------
	for (genvar g = 0; g < PINS; g++)
	begin : g_pin
		apc_pin_cell u_cell
		(
			.is_analog(analog_mask[g]),
			.dir(port2_direction[g]),
			.seg_sel(port2_function_select[g]),
			.chan_hit(chan_hit[g]),
			.latch_out(port2_latch[g]),
			.seg_data(segment_data[g]),
			.pad_in(pad_in[g]),
			.pad_out(next_pad_out[g]),
			.pad_oe(next_pad_oe[g]),
			.dig_in(next_dig_in[g]),
			.conv(next_convert[g])
		);
	end

	// pin outputs registered; reset keeps every buffer off
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pad_out <= '0;
			pad_oe <= '0;
			port2_digital_in <= '0;
			convert_pin <= '0;
		end
		else
		begin
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
			port2_digital_in <= next_dig_in;
			convert_pin <= next_convert;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_apa_write_first;
		cpu_req.wr && hit_apa && !wait_done;
	endsequence

	sequence s_apa_write_taken;
		!cpu_wait && wait_done;
	endsequence

	property p_apa_reset;
		disable iff (1'b0) rst |=> analog_pin_assignment == APC_APA_RESET;
	endproperty
	a_apa_reset: assert property (p_apa_reset) else $error("assignment reset value wrong");

	property p_dir_reset;
		disable iff (1'b0) rst |=> port2_direction == APC_DIR_RESET;
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction reset value wrong");

	property p_upper_zero;
		analog_pin_assignment[7:4] == 4'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("assignment upper bits not zero");

	property p_write_wait;
		s_apa_write_first |-> cpu_wait ##1 (cpu_req.wr && hit_apa) |-> s_apa_write_taken;
	endproperty
	a_write_wait: assert property (p_write_wait) else $error("assignment write wait wrong");

	// the register must not move in the stalled cycle, only after the held one
	property p_write_lands;
		s_apa_write_first ##1 (cpu_req.wr && hit_apa && cpu_req.wmask == '1)
			|=> analog_pin_assignment == ($past(cpu_req.wdata) & APC_SEL_MASK);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("assignment write lost after wait");

	property p_segment;
		1 |=> (pad_oe & $past(port2_function_select)) == $past(port2_function_select)
			&& ((pad_out ^ $past(segment_data)) & $past(port2_function_select)) == '0;
	endproperty
	a_segment: assert property (p_segment) else $error("segment pin not driving segment data");

	property p_no_analog_output;
		1 |=> (convert_pin & ~$past(port2_direction)) == '0;
	endproperty
	a_no_analog_output: assert property (p_no_analog_output) else $error("output-mode pin converted");

	property p_output_mode;
		1 |=> (~$past(port2_direction) & ~$past(port2_function_select) & ~pad_oe) == '0;
	endproperty
	a_output_mode: assert property (p_output_mode) else $error("output mode buffer off");

	property p_input_mode;
		1 |=> (pad_oe & $past(port2_direction) & ~$past(port2_function_select)) == '0;
	endproperty
	a_input_mode: assert property (p_input_mode) else $error("input mode buffer on");

	property p_all_digital;
		analog_pin_assignment[APC_SEL_W-1:0] == APC_SEL_ALL_DIGITAL |=> convert_pin == '0;
	endproperty
	a_all_digital: assert property (p_all_digital) else $error("conversion on all-digital code");

	property p_single_channel;
		1 |=> $onehot0(convert_pin) && (convert_pin & ~$past(chan_hit)) == '0;
	endproperty
	a_single_channel: assert property (p_single_channel) else $error("unpicked pin converted");

	property p_idle_analog;
		1 |=> (port2_digital_in & $past(analog_mask & port2_direction & ~port2_function_select)) == '0;
	endproperty
	a_idle_analog: assert property (p_idle_analog) else $error("analog pin digital path active");

endmodule // apc_analog_pin_config

`default_nettype wire

// file: apc_pkg.sv
//----------------------------------------------------------------------
// Purpose: shared constants and types for the port-2 analog pin config
// Assumes: byte-wide cpu register port with per-bit write mask
// Notes:   addresses are the cpu data-space addresses of the registers
//----------------------------------------------------------------------
package apc_pkg;

	// --------------------------------------------------------------
	// geometry
	// --------------------------------------------------------------
	localparam int APC_PINS = 8;
	localparam int APC_ADDR_W = 16;
	localparam int APC_SEL_W = 4;
	localparam int APC_CHAN_W = 3;

	// --------------------------------------------------------------
	// register map and reset values
	// --------------------------------------------------------------
	localparam logic [APC_ADDR_W-1:0] APC_ADDR_DIR = 16'hff22;
	localparam logic [APC_ADDR_W-1:0] APC_ADDR_APA = 16'hff8f;
	localparam logic [7:0] APC_DIR_RESET = 8'hff;
	localparam logic [7:0] APC_APA_RESET = 8'h08;

	// --------------------------------------------------------------
	// pin-select field of analog_pin_assignment
	// --------------------------------------------------------------
	localparam logic [7:0] APC_SEL_MASK = 8'h0f;
	localparam logic [APC_SEL_W-1:0] APC_SEL_ALL_ANALOG = 4'h0;
	localparam logic [APC_SEL_W-1:0] APC_SEL_ALL_DIGITAL = 4'h8;

	// --------------------------------------------------------------
	// direction bit encoding
	// --------------------------------------------------------------
	localparam logic APC_DIR_OUTPUT = 1'b0;
	localparam logic APC_DIR_INPUT = 1'b1;

	// cpu access toward the register port
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [APC_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic [7:0] wmask;
	} apc_cpu_req_t;

endpackage

// file: apc_pin_cell.sv
//----------------------------------------------------------------------
// Purpose: per-pin function mux for one shared port-2 pin
// Assumes: all inputs synchronous to mclk, purely combinational
// Notes:   owner registers the outputs
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module apc_pin_cell
	import apc_pkg::*;
(
	// configuration
	input wire logic is_analog,
	input wire logic dir,
	input wire logic seg_sel,
	input wire logic chan_hit,
	// data
	input wire logic latch_out,
	input wire logic seg_data,
	input wire logic pad_in,
	// results
	output logic pad_out,
	output logic pad_oe,
	output logic dig_in,
	output logic conv
);

	// priority: segment, then analog input, then plain port
	always_comb
	begin
		pad_out = 1'b0;
		pad_oe = 1'b0;
		dig_in = 1'b0;
		conv = 1'b0;
		if (seg_sel)
		begin
			pad_out = seg_data;
			pad_oe = 1'b1;
		end
		else if (is_analog && dir == APC_DIR_INPUT)
		begin
			conv = chan_hit;
		end
		else if (dir == APC_DIR_OUTPUT)
		begin
			// an analog pin in output mode is not analog: it acts as a port output
			pad_out = latch_out;
			pad_oe = 1'b1;
		end
		else
		begin
			dig_in = pad_in;
		end
	end

endmodule // apc_pin_cell

`default_nettype wire

// file: apc_analog_pin_config_tb.sv
//----------------------------------------------------------------------
// Purpose: self-checking bench for the port-2 analog pin config block
// Assumes: registered pin outputs, one wait cycle on assignment writes
// Notes:   inputs change only at the falling edge of mclk
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module apc_analog_pin_config_tb
	import apc_pkg::*;
;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic mclk, rst, cpu_wait;
	apc_cpu_req_t req;
	logic [2:0] chan;
	logic [7:0] rdata, fsel, latch, seg, pad_in, pad_out, pad_oe, din, conv, am;
	int error_cnt = 0;
	int n_checks = 0;

	apc_analog_pin_config dut
	(
		.mclk(mclk), .rst(rst), .cpu_req(req), .cpu_wait(cpu_wait), .cpu_rdata(rdata),
		.channel_selector(chan), .port2_function_select(fsel), .port2_latch(latch),
		.segment_data(seg), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.port2_digital_in(din), .convert_pin(conv)
	);

	// free-running clock, 10 ns period
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request is held until the edge that takes it; bounded wait on stall
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
		int n;
		req = '{wr:1'b1, rd:1'b0, addr:a, wdata:d, wmask:m};
		#1;
		chk({7'h00, cpu_wait}, {7'h00, a == APC_ADDR_APA});
		n = 0;
		while (cpu_wait === 1'b1 && n < 4)
		begin
			@(negedge mclk);
			n++;
		end
		chk({7'h00, cpu_wait}, 8'h00);
		chk(8'(n), {7'h00, a == APC_ADDR_APA});
		// a stall that never ends goes straight to the verdict
		if (n >= 4)
		begin
			error_cnt++;
			end_of_test();
		end
		@(negedge mclk);
		req.wr = 1'b0;
		// one idle cycle so a following call never re-raises wr in the same step
		@(negedge mclk);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		req = '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00, wmask:8'h00};
		@(negedge mclk);
		req.rd = 1'b0;
		chk(rdata, exp);
		// idle cycle between back-to-back requests
		@(negedge mclk);
	endtask

	// pins lag configuration by one edge, so two edges is settled
	task automatic pins(input logic [7:0] oe, input logic [7:0] po, input logic [7:0] di, input logic [7:0] cv);
		repeat (2) @(negedge mclk);
		chk(pad_oe, oe);
		chk(pad_out & oe, po);
		chk(din, di);
		chk(conv, cv);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd(APC_ADDR_APA, 8'h08);
		rd(APC_ADDR_DIR, 8'hff);
		rd(16'hff00, 8'h00);
		pins(8'h00, 8'h00, pad_in, 8'h00);
	endtask

	task automatic t_upper;
		wr(APC_ADDR_APA, 8'hf3, 8'hff);
		rd(APC_ADDR_APA, 8'h03);
	endtask

	// every legal code against every channel code
	task automatic t_codes;
		for (int c = 0; c <= 8; c++)
		begin
			wr(APC_ADDR_APA, 8'(c), 8'hff);
			am = 8'hff << c;
			for (int ch = 0; ch < 8; ch++)
			begin
				chan = 3'(ch);
				pins(8'h00, 8'h00, pad_in & ~am, am & (8'h01 << ch));
			end
		end
	endtask

	// output mode defeats analog use; then a single-bit direction write
	task automatic t_dir;
		wr(APC_ADDR_APA, 8'h00, 8'hff);
		latch = 8'ha5;
		wr(APC_ADDR_DIR, 8'h00, 8'hff);
		pins(8'hff, 8'ha5, 8'h00, 8'h00);
		// only pin 7 stays analog, and it alone goes to input mode
		wr(APC_ADDR_APA, 8'h07, 8'hff);
		chan = 3'h7;
		wr(APC_ADDR_DIR, 8'hff, 8'h80);
		rd(APC_ADDR_DIR, 8'h80);
		pins(8'h7f, 8'h25, 8'h00, 8'h80);
		latch = 8'h5a;
		pins(8'h7f, 8'h5a, 8'h00, 8'h80);
	endtask

	// segment select wins over analog input and over output mode
	task automatic t_seg;
		seg = 8'hc3;
		fsel = 8'h81;
		pins(8'hff, 8'hdb, 8'h00, 8'h00);
		fsel = 8'h00;
	endtask

	// ------------------------------------------------------------
	// verdict, main sequence and watchdog
	// ------------------------------------------------------------
	task automatic end_of_test;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		req = '0;
		rst = 1'b1;
		chan = 3'h0;
		fsel = 8'h00;
		latch = 8'h00;
		seg = 8'h00;
		pad_in = 8'h96;
		am = 8'h00;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		t_reset();
		t_upper();
		t_codes();
		t_dir();
		t_seg();
		end_of_test();
	end

	// a hang counts as a mismatch
	initial
	begin
		#100000;
		error_cnt++;
		end_of_test();
	end

endmodule // apc_analog_pin_config_tb

`default_nettype wire
